// ### hdl/rfl_pkg.sv
// rfl_pkg: constants, types and address decode of the reset factor block
package rfl_pkg;

    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned FACTOR_W = 16;
    localparam int unsigned VOLT_W   = 16;
    localparam int unsigned BKP_AW   = 4;
    localparam int unsigned CNT_W    = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FACTOR  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_VOLT    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RET1    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RET2    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RAM     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_BKP     = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_BKP_END = 8'h80;

    // reset factor flag positions
    localparam int unsigned FLG_POWER_ON = 0;
    localparam int unsigned FLG_LOW_VOLT = 3;
    localparam int unsigned FLG_SOFT_WDG = 4;
    localparam int unsigned FLG_HARD_WDG = 5;

    // voltage setting fields: bits 15..8 are the retained byte, mode in 11..8
    localparam int unsigned       VOLT_KEEP_LSB = 8;
    localparam int unsigned       MODE_LSB      = 8;
    localparam int unsigned       MODE_W        = 4;
    localparam logic [MODE_W-1:0] MODE_FULL     = 4'h1;
    localparam logic [MODE_W-1:0] MODE_KEEP     = 4'h4;

    localparam logic [FACTOR_W-1:0] FACTOR_RESET = 16'h0001;
    localparam logic [FACTOR_W-1:0] MASK_RESET   = 16'h0000;
    localparam logic [VOLT_W-1:0]   VOLT_RESET   = 16'h0100;
    localparam logic [DATA_W-1:0]   WORD_RESET   = 32'h0000_0000;

    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned WDG_PULSE_NS  = 400;
    localparam int unsigned WDG_PULSE_CYC = (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic sysRstN;
        logic busRstN;
        logic hwdgRstN;
        logic dbgStbyRstN;
    } rfl_resets_t;

    localparam rfl_resets_t RESETS_ON = 4'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_LOAD = 2'b01,
        BUS_DONE = 2'b10
    } rfl_bus_t;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_FACTOR = 3'b001,
        SEL_MASK   = 3'b010,
        SEL_VOLT   = 3'b011,
        SEL_RET1   = 3'b100,
        SEL_RET2   = 3'b101,
        SEL_RAM    = 3'b110,
        SEL_BKP    = 3'b111
    } rfl_sel_t;

    typedef struct packed {
        logic [2:0]          lvSync;
        logic                lvLevel;
        logic                lvFull;
        logic                swPend;
        logic                hwPend;
        logic [CNT_W-1:0]    wdgCnt;
        rfl_resets_t         resets;
        logic [FACTOR_W-1:0] factor;
        logic [FACTOR_W-1:0] mask;
        logic [VOLT_W-1:0]   volt;
        logic [DATA_W-1:0]   ret1;
        logic [DATA_W-1:0]   ret2;
        logic [DATA_W-1:0]   ramRet;
        logic                irq;
        rfl_bus_t            bus;
        logic [DATA_W-1:0]   prdata;
        logic                pready;
        logic                pslverr;
    } rfl_state_t;

    function automatic rfl_sel_t rfl_decode(input logic [ADDR_W-1:0] addr);
        rfl_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] != 2'h0) begin
            sel = SEL_NONE;
        end else if (addr == OFS_FACTOR) begin
            sel = SEL_FACTOR;
        end else if (addr == OFS_MASK) begin
            sel = SEL_MASK;
        end else if (addr == OFS_VOLT) begin
            sel = SEL_VOLT;
        end else if (addr == OFS_RET1) begin
            sel = SEL_RET1;
        end else if (addr == OFS_RET2) begin
            sel = SEL_RET2;
        end else if (addr == OFS_RAM) begin
            sel = SEL_RAM;
        end else if (addr >= OFS_BKP && addr < OFS_BKP_END) begin
            sel = SEL_BKP;
        end
        return sel;
    endfunction

endpackage

// ### hdl/rfl_backup_mem.sv
// rfl_backup_mem: retained backup word store with registered read data
`timescale 1ns/100ps
module rfl_backup_mem
    import rfl_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clear,
    input  wire logic             wrEn,
    input  wire logic             rdEn,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] rdData
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] word;
        logic [WIDTH-1:0]            rdWord;
    } rfl_mem_state_t;

    rfl_mem_state_t st_reg;
    rfl_mem_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // clear wins over a write in the same cycle
        if (clear) begin
            st_next.word = '0;
        end else if (wrEn) begin
            st_next.word[addr] = wrData;
        end
        if (rdEn) begin
            st_next.rdWord = st_reg.word[addr];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdData = st_reg.rdWord;

endmodule

// ### hdl/rfl_reset_factor.sv
// rfl_reset_factor: low-voltage and watchdog reset factors with reset factor register
`timescale 1ns/100ps
module rfl_reset_factor
    import rfl_pkg::*;
#(
    parameter bit SELECTABLE       = 1'b1,
    parameter bit WDG_KEEP_VOLT_HI = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              lowVoltage,
    input  wire logic              swdgUnderflow,
    input  wire logic              hwdgUnderflow,
    output rfl_resets_t            resets,
    output logic                   irq
);

    localparam logic [CNT_W-1:0] WDG_LOAD = CNT_W'(WDG_PULSE_CYC);
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h01;

    localparam rfl_state_t ST_RESET = '{
        lvSync:  3'h0,
        lvLevel: 1'b0,
        lvFull:  1'b1,
        swPend:  1'b0,
        hwPend:  1'b0,
        wdgCnt:  '0,
        resets:  RESETS_ON,
        factor:  FACTOR_RESET,
        mask:    MASK_RESET,
        volt:    VOLT_RESET,
        ret1:    WORD_RESET,
        ret2:    WORD_RESET,
        ramRet:  WORD_RESET,
        irq:     1'b0,
        bus:     BUS_IDLE,
        prdata:  WORD_RESET,
        pready:  1'b0,
        pslverr: 1'b0
    };

    rfl_state_t          st_reg;
    rfl_state_t          st_next;
    rfl_sel_t            sel;
    logic                busDone;
    logic                lvNext;
    logic                lvFullNext;
    logic                fullInit;
    logic                keepInit;
    logic                wdgEvent;
    logic                activeNext;
    logic                wrOk;
    logic                rdClr;
    logic                memRdEn;
    logic                memWrEn;
    logic [CNT_W-1:0]    cntNext;
    logic [FACTOR_W-1:0] evFlags;
    logic [FACTOR_W-1:0] pendFlags;
    logic [DATA_W-1:0]   memRdData;

    assign sel     = rfl_decode(paddr);
    assign busDone = (st_reg.bus == BUS_DONE) && psel && penable;
    assign memRdEn = (st_reg.bus == BUS_IDLE) && psel && penable;
    assign memWrEn = wrOk && (sel == SEL_BKP);

    always_comb begin
        st_next    = st_reg;
        lvNext     = st_reg.lvLevel;
        lvFullNext = st_reg.lvFull;
        cntNext    = st_reg.wdgCnt;
        evFlags    = '0;
        pendFlags  = '0;

        st_next.lvSync = {st_reg.lvSync[1:0], lowVoltage};
        // level follows once stages two and three agree
        if (st_reg.lvSync[1] == st_reg.lvSync[2]) begin
            lvNext = st_reg.lvSync[2];
        end
        st_next.lvLevel = lvNext;

        // scope caught as the reset asserts
        if (lvNext && !st_reg.lvLevel) begin
            lvFullNext = !SELECTABLE || (st_reg.volt[MODE_LSB +: MODE_W] != MODE_KEEP);
        end
        st_next.lvFull = lvFullNext;
        fullInit = lvNext && lvFullNext;
        keepInit = lvNext && !lvFullNext;

        wdgEvent = swdgUnderflow || hwdgUnderflow;
        if (wdgEvent) begin
            cntNext = WDG_LOAD;
        end else if (st_reg.wdgCnt != '0) begin
            cntNext = st_reg.wdgCnt - 1'b1;
        end
        st_next.wdgCnt = cntNext;

        // combined reset holds until the last factor ends
        activeNext = lvNext || (cntNext != '0);
        st_next.swPend = activeNext && (st_reg.swPend || swdgUnderflow);
        st_next.hwPend = activeNext && (st_reg.hwPend || hwdgUnderflow);
        evFlags[FLG_SOFT_WDG]   = swdgUnderflow;
        evFlags[FLG_HARD_WDG]   = hwdgUnderflow;
        pendFlags[FLG_SOFT_WDG] = st_next.swPend;
        pendFlags[FLG_HARD_WDG] = st_next.hwPend;

        st_next.resets.sysRstN = !activeNext;
        st_next.resets.busRstN = !activeNext;
        // watchdog domain reset only by hw watchdog or low voltage
        st_next.resets.hwdgRstN    = !(lvNext || st_next.hwPend);
        st_next.resets.dbgStbyRstN = !fullInit;

        // software writes and the read clear are held off while the system is in reset
        wrOk  = busDone && pwrite && !activeNext;
        rdClr = busDone && !pwrite && !activeNext && (sel == SEL_FACTOR);

        if (lvNext) begin
            st_next.factor = pendFlags;
            if (fullInit) begin
                st_next.factor[FLG_POWER_ON] = 1'b1;
            end else begin
                st_next.factor[FLG_LOW_VOLT] = 1'b1;
            end
        end else begin
            // flags kept; a new event wins over the read clear
            st_next.factor = (rdClr ? MASK_RESET : st_reg.factor) | evFlags;
        end

        if (activeNext) begin
            st_next.mask = MASK_RESET;
        end else if (wrOk && sel == SEL_MASK) begin
            st_next.mask = pwdata[FACTOR_W-1:0];
        end

        if (fullInit) begin
            st_next.volt = VOLT_RESET;
        end else if (keepInit || cntNext != '0) begin
            // retained upper byte, lower byte initialized
            st_next.volt[VOLT_KEEP_LSB-1:0] = VOLT_RESET[VOLT_KEEP_LSB-1:0];
            if (!keepInit && !WDG_KEEP_VOLT_HI) begin
                st_next.volt = VOLT_RESET;
            end
        end else if (wrOk && sel == SEL_VOLT) begin
            st_next.volt = pwdata[VOLT_W-1:0];
        end

        // return factors survive all but full scope
        if (fullInit) begin
            st_next.ret1 = WORD_RESET;
            st_next.ret2 = WORD_RESET;
        end else if (wrOk && sel == SEL_RET1) begin
            st_next.ret1 = pwdata;
        end else if (wrOk && sel == SEL_RET2) begin
            st_next.ret2 = pwdata;
        end

        if (lvNext) begin
            st_next.ramRet = WORD_RESET;
        end else if (wrOk && sel == SEL_RAM) begin
            st_next.ramRet = pwdata;
        end

        st_next.irq = |(st_next.factor & st_next.mask);

        case (st_reg.bus)
            BUS_IDLE: begin
                if (psel && penable) begin
                    st_next.bus = BUS_LOAD;
                end
            end
            BUS_LOAD: begin
                st_next.bus     = BUS_DONE;
                st_next.pready  = 1'b1;
                st_next.pslverr = (sel == SEL_NONE);
                st_next.prdata  = WORD_RESET;
                if (!pwrite) begin
                    case (sel)
                        SEL_FACTOR: st_next.prdata = {16'h0000, st_reg.factor};
                        SEL_MASK:   st_next.prdata = {16'h0000, st_reg.mask};
                        SEL_VOLT:   st_next.prdata = {16'h0000, st_reg.volt};
                        SEL_RET1:   st_next.prdata = st_reg.ret1;
                        SEL_RET2:   st_next.prdata = st_reg.ret2;
                        SEL_RAM:    st_next.prdata = st_reg.ramRet;
                        SEL_BKP:    st_next.prdata = memRdData;
                        default:    st_next.prdata = WORD_RESET;
                    endcase
                end
            end
            BUS_DONE: begin
                st_next.bus     = BUS_IDLE;
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.prdata  = WORD_RESET;
            end
            default: begin
                st_next.bus = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // backup words survive all but full scope
    rfl_backup_mem #(
        .WIDTH (DATA_W),
        .DEPTH (16),
        .AW    (BKP_AW)
    ) u_backup (
        .clk    (clk),
        .nrst   (nrst),
        .clear  (fullInit),
        .wrEn   (memWrEn),
        .rdEn   (memRdEn),
        .addr   (paddr[2 +: BKP_AW]),
        .wrData (pwdata),
        .rdData (memRdData)
    );

    assign prdata  = st_reg.prdata;
    assign pready  = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign resets  = st_reg.resets;
    assign irq     = st_reg.irq;

    property p_lv_assert;
        @(posedge clk) disable iff (!nrst)
        st_reg.lvSync[2:1] == 2'b11 |=> !resets.sysRstN && !resets.busRstN;
    endproperty
    a_lv_assert: assert property (p_lv_assert) else $error("lv reset missing");

    property p_lv_release;
        @(posedge clk) disable iff (!nrst)
        $fell(st_reg.lvLevel) |-> $past(st_reg.lvSync[2:1]) == 2'b00;
    endproperty
    a_lv_release: assert property (p_lv_release) else $error("lv early release");

    property p_lv_full;
        @(posedge clk) disable iff (!nrst)
        st_reg.lvLevel && st_reg.lvFull |-> st_reg.factor[FLG_POWER_ON]
            && st_reg.volt == VOLT_RESET && !resets.dbgStbyRstN;
    endproperty
    a_lv_full: assert property (p_lv_full) else $error("lv full scope wrong");

    property p_lv_keep_flag;
        @(posedge clk) disable iff (!nrst)
        st_reg.lvLevel && !st_reg.lvFull
            |-> st_reg.factor[FLG_LOW_VOLT] && !st_reg.factor[FLG_POWER_ON];
    endproperty
    a_lv_keep_flag: assert property (p_lv_keep_flag) else $error("lv flag wrong");

    property p_lv_keep_hold;
        @(posedge clk) disable iff (!nrst)
        st_reg.lvLevel && !st_reg.lvFull ##1 st_reg.lvLevel
            |-> $stable(st_reg.volt[VOLT_W-1:VOLT_KEEP_LSB]) && $stable(st_reg.ret1)
            && $stable(st_reg.ret2);
    endproperty
    a_lv_keep_hold: assert property (p_lv_keep_hold) else $error("lv lost data");

    property p_wdg_pulse;
        @(posedge clk) disable iff (!nrst)
        swdgUnderflow || hwdgUnderflow |=> (!resets.sysRstN) [*8];
    endproperty
    a_wdg_pulse: assert property (p_wdg_pulse) else $error("wdg pulse short");

    property p_wdg_end;
        @(posedge clk) disable iff (!nrst)
        st_reg.wdgCnt == CNT_LAST && !wdgEvent && !lvNext
            |=> resets.sysRstN && resets.busRstN;
    endproperty
    a_wdg_end: assert property (p_wdg_end) else $error("wdg reset stuck");

    property p_sw_spares;
        @(posedge clk) disable iff (!nrst)
        swdgUnderflow && !hwdgUnderflow && !st_reg.hwPend && !lvNext
            |=> resets.hwdgRstN && resets.dbgStbyRstN && !resets.sysRstN;
    endproperty
    a_sw_spares: assert property (p_sw_spares) else $error("sw wdg scope wrong");

    property p_wdg_keep;
        @(posedge clk) disable iff (!nrst)
        cntNext != '0 && !lvNext |=> $stable(st_reg.ramRet) && $stable(st_reg.ret1)
            && $stable(st_reg.ret2);
    endproperty
    a_wdg_keep: assert property (p_wdg_keep) else $error("wdg lost data");

    property p_sw_flag;
        @(posedge clk) disable iff (!nrst)
        swdgUnderflow |=> st_reg.factor[FLG_SOFT_WDG];
    endproperty
    a_sw_flag: assert property (p_sw_flag) else $error("sw wdg flag missing");

    property p_hw_scope;
        @(posedge clk) disable iff (!nrst)
        hwdgUnderflow && !lvNext |=> !resets.hwdgRstN && resets.dbgStbyRstN;
    endproperty
    a_hw_scope: assert property (p_hw_scope) else $error("hw wdg scope wrong");

    property p_hw_flag;
        @(posedge clk) disable iff (!nrst)
        hwdgUnderflow |=> st_reg.factor[FLG_HARD_WDG] && !resets.busRstN;
    endproperty
    a_hw_flag: assert property (p_hw_flag) else $error("hw wdg flag missing");

    property p_combined;
        @(posedge clk) disable iff (!nrst)
        st_reg.lvLevel && st_reg.swPend |-> st_reg.factor[FLG_SOFT_WDG] && !resets.sysRstN;
    endproperty
    a_combined: assert property (p_combined) else $error("coinciding factor lost");

endmodule

// ### tb/rfl_far_model.sv
// rfl_far_model: voltage monitor and both watchdog timers facing the block
`timescale 1ns/100ps
module rfl_far_model (
    input  wire logic clk,
    output logic      lowVoltage,
    output logic      swdgUnderflow,
    output logic      hwdgUnderflow
);
    initial begin
        lowVoltage = 1'b0;
        swdgUnderflow = 1'b0;
        hwdgUnderflow = 1'b0;
    end
    // supply level stays where it is put until told otherwise
    task automatic setLow(input logic lv);
        @(posedge clk);
        lowVoltage <= lv;
    endtask
    // one-cycle underflow on either timer or on both at once
    task automatic underflow(input logic sw, input logic hw);
        @(posedge clk);
        swdgUnderflow <= sw;
        hwdgUnderflow <= hw;
        @(posedge clk);
        swdgUnderflow <= 1'b0;
        hwdgUnderflow <= 1'b0;
    endtask
endmodule

// ### tb/rfl_reset_factor_tb_top.sv
// rfl_reset_factor_tb_top: model-checked bench for the reset factor block
`timescale 1ns/100ps
module rfl_reset_factor_tb_top
    import rfl_pkg::*;
;
    logic              clk;
    logic              nrst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              lowVoltage;
    logic              swdgUnderflow;
    logic              hwdgUnderflow;
    logic              irq;
    rfl_resets_t       resets;
    int                errors;
    int                testsRun;
    int                n;
    rfl_resets_t       first;
    int unsigned       mFac, mMask, mVolt, mRet1, mRet2, mRam;
    int unsigned       mBkp[16];

    rfl_reset_factor DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lowVoltage(lowVoltage), .swdgUnderflow(swdgUnderflow),
        .hwdgUnderflow(hwdgUnderflow), .resets(resets), .irq(irq));
    rfl_far_model FAR (.clk(clk), .lowVoltage(lowVoltage), .swdgUnderflow(swdgUnderflow),
        .hwdgUnderflow(hwdgUnderflow));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] rd, output logic err);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(what, r, exp);
    endtask

    // kind 0 full low-voltage, 1 keep low-voltage, 2 software and 3 hardware watchdog
    function automatic void mdlReset(input int kind);
        mMask = 0;
        if (kind == 0) begin
            mFac = 'h1;
            mVolt = 'h100;
            mRet1 = 0;
            mRet2 = 0;
            mRam = 0;
            foreach (mBkp[i]) mBkp[i] = 0;
        end else begin
            mVolt = mVolt & 'hFF00;
            if (kind == 1) mFac = 'h8;
            if (kind == 1) mRam = 0;
            if (kind == 2) mFac = mFac | 'h10;
            if (kind == 3) mFac = mFac | 'h20;
        end
    endfunction

    task automatic fill(input logic [MODE_W-1:0] mode);
        logic [DATA_W-1:0] v;
        v = ($urandom() & 32'h0000_F0FF) | {20'h0_0000, mode, 8'h00};
        wr(OFS_VOLT, v);
        mVolt = v;
        v = $urandom();
        wr(OFS_RET1, v);
        mRet1 = v;
        v = $urandom();
        wr(OFS_RET2, v);
        mRet2 = v;
        v = $urandom();
        wr(OFS_RAM, v);
        mRam = v;
        for (int k = 0; k < 16; k++) begin
            v = $urandom();
            wr(OFS_BKP + 8'(4 * k), v);
            mBkp[k] = v;
        end
        wr(OFS_FACTOR, $urandom());
    endtask

    task automatic chkRegs();
        logic [DATA_W-1:0] r;
        logic              e;
        int                k;
        k = $urandom_range(15);
        rdChk("mask", OFS_MASK, mMask);
        rdChk("voltage", OFS_VOLT, mVolt);
        rdChk("return1", OFS_RET1, mRet1);
        rdChk("return2", OFS_RET2, mRet2);
        rdChk("ramRetention", OFS_RAM, mRam);
        rdChk("backup", OFS_BKP + 8'(4 * k), mBkp[k]);
        rdChk("factor", OFS_FACTOR, mFac);
        mFac = 0;
        rdChk("factorCleared", OFS_FACTOR, 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000, r, e);
        check("unmappedErr", {31'h0, e}, 32'h0000_0001);
    endtask

    // counts reset cycles from now until the system reset lets go
    task automatic waitRel(output int cnt, output rfl_resets_t firstSeen);
        bit done;
        cnt = 0;
        done = 1'b0;
        firstSeen = 4'hF;
        for (int i = 0; i < 300 && !done; i++) begin
            #1;
            if (resets.sysRstN === 1'b0 && cnt == 0) firstSeen = resets;
            if (resets.sysRstN === 1'b0) cnt++;
            else if (cnt > 0) done = 1'b1;
            if (!done) @(posedge clk);
        end
        // a reset that never comes or never ends is a failure
        if (!done) begin
            errors++;
            conclude();
        end
    endtask

    task automatic lvHold(input int cyc, input logic [3:0] exp);
        for (int i = 0; i < cyc; i++) begin
            @(posedge clk);
            #1;
            check("lvResets", 32'(resets), {28'h000_0000, exp});
        end
    endtask

    task automatic lvAssert();
        int i;
        FAR.setLow(1'b1);
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            if (resets.sysRstN === 1'b0) break;
        end
        check("lvFall", 32'(i < 10), 32'h0000_0001);
        if (i == 10) conclude();
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        errors = 0;
        testsRun = 0;
        void'($urandom(83682));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        mdlReset(0);
        chkRegs();
        $display("test powerOn done");
        fill(MODE_FULL);
        FAR.underflow(1'b1, 1'b0);
        waitRel(n, first);
        check("swPulse", 32'(n), WDG_PULSE_CYC);
        check("swResets", 32'(first), 32'h0000_0003);
        mdlReset(2);
        chkRegs();
        $display("test softWatchdog done");
        fill(MODE_FULL);
        FAR.underflow(1'b0, 1'b1);
        waitRel(n, first);
        check("hwPulse", 32'(n), WDG_PULSE_CYC);
        check("hwResets", 32'(first), 32'h0000_0001);
        mdlReset(3);
        wr(OFS_MASK, 32'h0000_0020);
        repeat (2) @(posedge clk);
        check("irqRaised", {31'h0, irq}, 32'h0000_0001);
        wr(OFS_MASK, 32'h0000_0010);
        repeat (2) @(posedge clk);
        check("irqMasked", {31'h0, irq}, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0020);
        mMask = 'h20;
        rdChk("hwFactor", OFS_FACTOR, mFac);
        mFac = 0;
        repeat (2) @(posedge clk);
        check("irqCleared", {31'h0, irq}, 32'h0000_0000);
        chkRegs();
        $display("test hardWatchdog done");
        fill(MODE_FULL);
        lvAssert();
        lvHold(30, 4'h0);
        FAR.setLow(1'b0);
        waitRel(n, first);
        mdlReset(0);
        chkRegs();
        $display("test lowVoltageFull done");
        fill(MODE_KEEP);
        lvAssert();
        lvHold(5, 4'h1);
        FAR.underflow(1'b1, 1'b0);
        lvHold(30, 4'h1);
        FAR.setLow(1'b0);
        waitRel(n, first);
        mdlReset(1);
        mdlReset(2);
        chkRegs();
        $display("test lowVoltageKeep done");
        fill(MODE_KEEP);
        FAR.underflow(1'b1, 1'b1);
        waitRel(n, first);
        check("bothPulse", 32'(n), WDG_PULSE_CYC);
        check("bothResets", 32'(first), 32'h0000_0001);
        mdlReset(2);
        mdlReset(3);
        chkRegs();
        // a one-cycle supply dip must be filtered out
        FAR.setLow(1'b1);
        FAR.setLow(1'b0);
        lvHold(6, 4'hF);
        // second reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        mdlReset(0);
        chkRegs();
        $display("test coincidingAndReset done");
        conclude();
    end
endmodule
